// File: hw/crs_core_regs.sv
// Notes on behaviour
// [RULE1] bank_select maps R0-R7 to 00H, 08H, 10H or 18H banks.
// [RULE2] Parity flag follows the operand register, giving even parity.
// [RULE3] Stack pointer holds 07H after reset.
// [RULE4] Stack pointer pre-increments on push or call; first byte at 08H.
// [RULE5] Data pointers are 16 bits, loaded whole or by byte halves.
// [RULE6] Select bit 1 picks second pointer, 0 picks the first.
// [RULE7] Pointer instructions read and update only the selected pointer.
// [RULE8] Indirect external moves take high byte from page register, reset 00H. Code takes it from PORT2_LATCH while xram_disable is 1.
// [RULE9] Each page spans 256 bytes.
// [RULE10] Pages beyond the 1K area drive the page value onto port 2.
// [RULE11] Pointer moves above 03FFH raise external memory control.
// [RULE12] Expanded RAM is reachable only by external moves.
// [RULE13] Timing select 0 gives 2T, 1 gives 1T; reset is 2T.
// [RULE14] Code protect flag is read-only status.
// [RULE15] Latch strobe: 00 toggles, 01 off, 10 on accesses, 11 reserved.
// [RULE16] xram_disable 0 enables the expanded RAM, 1 disables it.
// [RULE17] in_system_prog_enable 1 enables programming, 0 disables it.
// [RULE18] Multiply and divide use aux math register; otherwise scratch.
// [RULE19] User flags zero and one are free read-write bits.
// [RULE20] Operand register is the default source and destination.
// [RULE21] Arithmetic updates carry, half carry and overflow flags.
module crs_core_regs #(
  parameter int XRAM_BYTES = crs_pkg::XRAM_BYTES_DEFAULT
) (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input crs_pkg::crs_sfr_req_type SFR_REQ,
  output logic [7:0] SFR_RDATA,
  output logic SFR_ACK,
  input crs_pkg::crs_core_op_type CORE_OP,
  input wire logic [7:0] PORT2_LATCH,
  input wire logic CODE_PROTECT_PIN,
  output logic [7:0] ACC_VALUE,
  output logic [7:0] B_VALUE,
  output logic [7:0] PSW_VALUE,
  output logic [7:0] SP_VALUE,
  output logic [7:0] STACK_ADDR,
  output logic [7:0] BANK_BASE,
  output logic [15:0] DATA_POINTER_VALUE,
  output crs_pkg::crs_xbus_type XBUS,
  output logic ALE_OUT,
  output logic TIMING_1T,
  output logic XRAM_ENABLE,
  output logic ISP_ENABLE
);
  import crs_pkg::*;

  // Expanded RAM limits derived from its size
  localparam logic [15:0] XRAM_TOP = 16'(XRAM_BYTES - 1);
  // [RULE9] page span
  localparam logic [7:0] PAGE_TOP = 8'(XRAM_BYTES / PAGE_BYTES - 1);

  // Size must be whole pages and fit the 16-bit external space
  if (XRAM_BYTES < PAGE_BYTES || XRAM_BYTES > 65536 ||
      (XRAM_BYTES % PAGE_BYTES) != 0) begin : g_bad_size
    $error("XRAM_BYTES must be a multiple of 256 up to 65536");
  end

  logic [7:0] acc;
  logic [7:0] b_reg;
  logic [7:1] program_status_word;
  logic parity;
  logic [7:0] sp;
  logic [7:0] stack_addr;
  logic [7:0] bank_base;
  logic [15:0] dptr0;
  logic [15:0] second_data_pointer;
  logic [15:0] data_pointer_active;
  logic [7:0] page;
  logic [7:0] ifc;
  logic [7:0] route;
  logic [SYNC_STAGES-1:0] code_protect_flag_sync;
  logic code_protect_flag;
  logic [7:0] rdata;
  logic ack;
  crs_xbus_type xbus;
  logic ale;

  logic [7:0] next_acc;
  logic [15:0] next_dptr0;
  logic [15:0] next_second_data_pointer;
  logic next_sel;
  logic [7:0] md_a;
  logic [7:0] md_b;
  logic md_cy;
  logic md_ov;
  logic math_busy;
  logic sel;
  logic xram_en;
  crs_ale_mode_type ale_mode;

  // True when the register bus writes the given address
  function automatic logic wr_hit(input crs_sfr_req_type req,
                                  input logic [7:0] addr);
    wr_hit = req.wr && (req.addr == addr);
  endfunction

  // True for every address this block answers
  function automatic logic is_mapped(input logic [7:0] addr);
    case (addr)
      ADDR_SP, ADDR_DPL, ADDR_DPH, ADDR_SECOND_POINTER_LOW, ADDR_SECOND_POINTER_HIGH, ADDR_PAGE,
      ADDR_IFC, ADDR_ROUTE, ADDR_PSW, ADDR_ACC, ADDR_B: begin
        is_mapped = 1'b1;
      end
      default: begin
        is_mapped = 1'b0;
      end
    endcase
  endfunction

  // Bank base address for R0 of the selected bank
  function automatic logic [7:0] bank_of(input logic [1:0] rs);
    bank_of = 8'({rs, 3'b000});
  endfunction

  assign sel = route[ROUTE_DPS];
  assign ale_mode = crs_ale_mode_type'(ifc[IFC_ALE_HI:IFC_ALE_LO]);
  assign math_busy = (CORE_OP.math_op != MATH_NONE);

  // [RULE18] multiply and divide against the aux math register
  crs_muldiv u_muldiv (
    .opa(acc),
    .opb(b_reg),
    .op(CORE_OP.math_op),
    .res_a(md_a),
    .res_b(md_b),
    .cy(md_cy),
    .ov(md_ov)
  );

  // Operand register next value; a register bus write beats the core
  always_comb begin
    next_acc = acc;
    if (wr_hit(SFR_REQ, ADDR_ACC)) begin
      next_acc = SFR_REQ.wdata;
    end else if (math_busy) begin
      next_acc = md_a;
    end else if (CORE_OP.acc_load) begin
      // [RULE20] default destination
      next_acc = CORE_OP.acc_data;
    end
  end

  // Operand register with its parity kept alongside
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      acc <= RST_BYTE;
      parity <= 1'b0;
    end else begin
      acc <= next_acc;
      // [RULE2] even parity flag
      parity <= ^next_acc;
    end
  end

  // Aux math register, scratch storage unless a multiply or divide runs
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      b_reg <= RST_BYTE;
    end else if (wr_hit(SFR_REQ, ADDR_B)) begin
      b_reg <= SFR_REQ.wdata;
    end else if (math_busy) begin
      // [RULE18] second operand and result
      b_reg <= md_b;
    end
  end

  // Status word; parity is never written, it tracks the operand
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      program_status_word <= RST_BYTE[7:1];
      bank_base <= RST_BYTE;
    end else if (wr_hit(SFR_REQ, ADDR_PSW)) begin
      // [RULE19] user flags stored as written
      program_status_word <= SFR_REQ.wdata[7:1];
      // [RULE1] bank base from select
      bank_base <= bank_of(SFR_REQ.wdata[PSW_RS_HI:PSW_RS_LO]);
    end else if (math_busy) begin
      program_status_word[PSW_CY] <= md_cy;
      program_status_word[PSW_OV] <= md_ov;
    end else if (CORE_OP.flag_load) begin
      // [RULE21] arithmetic flag update
      program_status_word[PSW_CY] <= CORE_OP.cy;
      program_status_word[PSW_AC] <= CORE_OP.ac;
      program_status_word[PSW_OV] <= CORE_OP.ov;
    end
  end

  // Stack pointer; pop reads the top before it moves down
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      // [RULE3] reset value
      sp <= RST_SP;
      stack_addr <= RST_SP;
    end else if (wr_hit(SFR_REQ, ADDR_SP)) begin
      sp <= SFR_REQ.wdata;
      stack_addr <= SFR_REQ.wdata;
    end else begin
      case (CORE_OP.stack_op)
        STK_PUSH: begin
          // [RULE4] increment before write
          sp <= 8'(sp + 8'h01);
          stack_addr <= 8'(sp + 8'h01);
        end
        STK_POP: begin
          stack_addr <= sp;
          sp <= 8'(sp - 8'h01);
        end
        default: begin
        end
      endcase
    end
  end

  // Both pointers; byte writes reach either by address
  always_comb begin
    next_dptr0 = dptr0;
    next_second_data_pointer = second_data_pointer;
    // [RULE5] whole or byte-wise loading
    if (wr_hit(SFR_REQ, ADDR_DPL)) begin
      next_dptr0[7:0] = SFR_REQ.wdata;
    end
    if (wr_hit(SFR_REQ, ADDR_DPH)) begin
      next_dptr0[15:8] = SFR_REQ.wdata;
    end
    if (wr_hit(SFR_REQ, ADDR_SECOND_POINTER_LOW)) begin
      next_second_data_pointer[7:0] = SFR_REQ.wdata;
    end
    if (wr_hit(SFR_REQ, ADDR_SECOND_POINTER_HIGH)) begin
      next_second_data_pointer[15:8] = SFR_REQ.wdata;
    end
    // [RULE7] core touches the selected pointer only
    if (!SFR_REQ.wr) begin
      if (CORE_OP.data_pointer_load) begin
        if (sel) begin
          next_second_data_pointer = CORE_OP.data_pointer_data;
        end else begin
          next_dptr0 = CORE_OP.data_pointer_data;
        end
      end else if (CORE_OP.data_pointer_inc) begin
        if (sel) begin
          next_second_data_pointer = 16'(second_data_pointer + 16'h0001);
        end else begin
          next_dptr0 = 16'(dptr0 + 16'h0001);
        end
      end
    end
  end

  // Pointer select as it stands after this cycle
  always_comb begin
    next_sel = sel;
    if (wr_hit(SFR_REQ, ADDR_ROUTE)) begin
      next_sel = SFR_REQ.wdata[ROUTE_DPS];
    end
  end

  // Pointer storage and the registered active copy
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      dptr0 <= RST_WORD;
      second_data_pointer <= RST_WORD;
      data_pointer_active <= RST_WORD;
    end else begin
      dptr0 <= next_dptr0;
      second_data_pointer <= next_second_data_pointer;
      // [RULE6] select bit chooses pointer
      data_pointer_active <= next_sel ? next_second_data_pointer : next_dptr0;
    end
  end

  // Page, interface control and route registers
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      // [RULE8] page 0 after reset
      page <= RST_BYTE;
      ifc <= RST_BYTE;
      xram_en <= 1'b1;
      route <= RST_BYTE;
    end else begin
      if (wr_hit(SFR_REQ, ADDR_PAGE)) begin
        page <= SFR_REQ.wdata;
      end
      if (wr_hit(SFR_REQ, ADDR_IFC)) begin
        // [RULE14] protect bit not writable
        ifc <= SFR_REQ.wdata & IFC_WR_MASK;
        // Own flop so the enable output needs no inverter
        xram_en <= ~SFR_REQ.wdata[IFC_XRAM_DISABLE];
      end
      if (wr_hit(SFR_REQ, ADDR_ROUTE)) begin
        route <= SFR_REQ.wdata & ROUTE_WR_MASK;
      end
    end
  end

  // Code protect level from the flash option pin, three stages
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      code_protect_flag_sync <= '0;
    end else begin
      code_protect_flag_sync <= {code_protect_flag_sync[SYNC_STAGES-2:0], CODE_PROTECT_PIN};
    end
  end

  // Accept a change only when the last two stages agree
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      code_protect_flag <= 1'b0;
    end else if (code_protect_flag_sync[2] == code_protect_flag_sync[1]) begin
      code_protect_flag <= code_protect_flag_sync[2];
    end
  end

  // Register bus read port; reads see state before this cycle's write
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata <= RST_BYTE;
      ack <= 1'b0;
    end else begin
      ack <= (SFR_REQ.rd || SFR_REQ.wr) && is_mapped(SFR_REQ.addr);
      // Unmapped and write-only cycles return zero
      rdata <= RST_BYTE;
      if (SFR_REQ.rd) begin
        case (SFR_REQ.addr)
          ADDR_SP: rdata <= sp;
          ADDR_DPL: rdata <= dptr0[7:0];
          ADDR_DPH: rdata <= dptr0[15:8];
          ADDR_SECOND_POINTER_LOW: rdata <= second_data_pointer[7:0];
          ADDR_SECOND_POINTER_HIGH: rdata <= second_data_pointer[15:8];
          ADDR_PAGE: rdata <= page;
          // [RULE14] protect status read back
          ADDR_IFC: rdata <= {ifc[7], code_protect_flag, ifc[5:0]};
          ADDR_ROUTE: rdata <= route;
          ADDR_PSW: rdata <= {program_status_word, parity};
          ADDR_ACC: rdata <= acc;
          ADDR_B: rdata <= b_reg;
          default: rdata <= RST_BYTE;
        endcase
      end
    end
  end

  // External move address decode, one request per pulse.
  // Internal direct and indirect moves have no path here, so the expanded
  // RAM is never aliased into the direct or indirect data space.
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      xbus <= '0;
    end else begin
      xbus.valid <= 1'b0;
      // [RULE12] only external moves decode here
      if (CORE_OP.xmove_go) begin
        xbus.valid <= 1'b1;
        xbus.write <= CORE_OP.xmove_write;
        if (CORE_OP.xmove_indirect) begin
          // [RULE8] page register supplies high byte
          if (xram_en) begin
            xbus.addr <= {page, CORE_OP.xmove_low};
            xbus.internal <= (page <= PAGE_TOP);
            xbus.external <= (page > PAGE_TOP);
            // [RULE10] page value driven on port 2
            xbus.p2_drive <= (page > PAGE_TOP);
          end else begin
            // Disabled RAM: port 2 latch holds the high byte
            xbus.addr <= {PORT2_LATCH, CORE_OP.xmove_low};
            xbus.internal <= 1'b0;
            xbus.external <= 1'b1;
            xbus.p2_drive <= 1'b0;
          end
        end else begin
          xbus.addr <= data_pointer_active;
          // [RULE11] external control above the RAM top
          xbus.internal <= xram_en && (data_pointer_active <= XRAM_TOP);
          xbus.external <= !(xram_en && (data_pointer_active <= XRAM_TOP));
          xbus.p2_drive <= 1'b0;
        end
      end
    end
  end

  // Address latch strobe policy; reserved code behaves as off
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ale <= 1'b0;
    end else begin
      // [RULE15] strobe output policy
      case (ale_mode)
        ALE_ALWAYS: ale <= ~ale;
        ALE_OFF: ale <= 1'b0;
        ALE_ACCESS: begin
          ale <= CORE_OP.xmove_go && !(CORE_OP.xmove_indirect ?
                 (xram_en && page <= PAGE_TOP) :
                 (xram_en && data_pointer_active <= XRAM_TOP));
        end
        default: ale <= 1'b0;
      endcase
    end
  end

  // Every output is a flip-flop or a bit of one
  assign SFR_RDATA = rdata;
  assign SFR_ACK = ack;
  assign ACC_VALUE = acc;
  assign B_VALUE = b_reg;
  assign PSW_VALUE = {program_status_word, parity};
  assign SP_VALUE = sp;
  assign STACK_ADDR = stack_addr;
  assign BANK_BASE = bank_base;
  assign DATA_POINTER_VALUE = data_pointer_active;
  assign XBUS = xbus;
  assign ALE_OUT = ale;
  // [RULE13] instruction timing mode
  assign TIMING_1T = ifc[IFC_ITS];
  // [RULE16] expanded RAM enable
  assign XRAM_ENABLE = xram_en;
  // [RULE17] programming function enable
  assign ISP_ENABLE = ifc[IFC_IN_SYSTEM_PROG_ENABLE];

endmodule

// File: hw/crs_pkg.sv
package crs_pkg;

  // Special function register addresses
  localparam logic [7:0] ADDR_SP = 8'h81;
  localparam logic [7:0] ADDR_DPL = 8'h82;
  localparam logic [7:0] ADDR_DPH = 8'h83;
  localparam logic [7:0] ADDR_SECOND_POINTER_LOW = 8'h84;
  localparam logic [7:0] ADDR_SECOND_POINTER_HIGH = 8'h85;
  localparam logic [7:0] ADDR_PAGE = 8'h86;
  localparam logic [7:0] ADDR_IFC = 8'h8F;
  localparam logic [7:0] ADDR_ROUTE = 8'h91;
  localparam logic [7:0] ADDR_PSW = 8'hD0;
  localparam logic [7:0] ADDR_ACC = 8'hE0;
  localparam logic [7:0] ADDR_B = 8'hF0;

  // Values after reset
  localparam logic [7:0] RST_SP = 8'h07;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  // Status word field positions
  localparam int PSW_CY = 7;
  localparam int PSW_AC = 6;
  localparam int PSW_F0 = 5;
  localparam int PSW_RS_HI = 4;
  localparam int PSW_RS_LO = 3;
  localparam int PSW_OV = 2;
  localparam int PSW_F1 = 1;
  localparam int PSW_P = 0;

  // Interface control field positions and writable bits
  localparam int IFC_ITS = 7;
  localparam int IFC_CODE_PROTECT_FLAG = 6;
  localparam int IFC_ALE_HI = 3;
  localparam int IFC_ALE_LO = 2;
  localparam int IFC_XRAM_DISABLE = 1;
  localparam int IFC_IN_SYSTEM_PROG_ENABLE = 0;
  localparam logic [7:0] IFC_WR_MASK = 8'h8F;

  // Peripheral route register: pointer select and implemented bits
  localparam int ROUTE_DPS = 0;
  localparam logic [7:0] ROUTE_WR_MASK = 8'hBB;

  // Expanded RAM geometry
  localparam int XRAM_BYTES_DEFAULT = 1024;
  localparam int PAGE_BYTES = 256;
  localparam int BANK_SHIFT = 3;

  // Pin input synchroniser depth
  localparam int SYNC_STAGES = 3;

  typedef enum logic [1:0] {
    ALE_ALWAYS = 2'b00,
    ALE_OFF = 2'b01,
    ALE_ACCESS = 2'b10,
    ALE_RSVD = 2'b11
  } crs_ale_mode_type;

  typedef enum logic [1:0] {
    STK_NONE = 2'b00,
    STK_PUSH = 2'b01,
    STK_POP = 2'b11
  } crs_stack_op_type;

  typedef enum logic [1:0] {
    MATH_NONE = 2'b00,
    MATH_MUL = 2'b01,
    MATH_DIV = 2'b11
  } crs_math_op_type;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } crs_sfr_req_type;

  typedef struct packed {
    logic acc_load;
    logic [7:0] acc_data;
    logic flag_load;
    logic cy;
    logic ac;
    logic ov;
    crs_stack_op_type stack_op;
    crs_math_op_type math_op;
    logic data_pointer_load;
    logic [15:0] data_pointer_data;
    logic data_pointer_inc;
    logic xmove_go;
    logic xmove_indirect;
    logic xmove_write;
    logic [7:0] xmove_low;
  } crs_core_op_type;

  typedef struct packed {
    logic valid;
    logic write;
    logic internal;
    logic external;
    logic p2_drive;
    logic [15:0] addr;
  } crs_xbus_type;

endpackage

// File: hw/crs_muldiv.sv
module crs_muldiv (
  input wire logic [7:0] opa,
  input wire logic [7:0] opb,
  input crs_pkg::crs_math_op_type op,
  output logic [7:0] res_a,
  output logic [7:0] res_b,
  output logic cy,
  output logic ov
);
  import crs_pkg::*;

  logic [15:0] product;

  // Single-cycle multiply and divide on the operand pair
  always_comb begin
    product = 16'(opa) * 16'(opb);
    res_a = opa;
    res_b = opb;
    cy = 1'b0;
    ov = 1'b0;
    case (op)
      MATH_MUL: begin
        res_a = product[7:0];
        res_b = product[15:8];
        ov = |product[15:8];
      end
      MATH_DIV: begin
        // Divide by zero keeps both operands, only flags the error
        if (opb == 8'h00) begin
          ov = 1'b1;
        end else begin
          res_a = opa / opb;
          res_b = opa % opb;
        end
      end
      default: begin
      end
    endcase
  end

endmodule

// File: bench/crs_core_regs_assertions.sv
module crs_core_regs_assertions #(
  parameter int XRAM_BYTES = crs_pkg::XRAM_BYTES_DEFAULT
) (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input crs_pkg::crs_sfr_req_type SFR_REQ,
  input wire logic [7:0] SFR_RDATA,
  input wire logic SFR_ACK,
  input crs_pkg::crs_core_op_type CORE_OP,
  input wire logic [7:0] PORT2_LATCH,
  input wire logic CODE_PROTECT_PIN,
  input wire logic [7:0] ACC_VALUE,
  input wire logic [7:0] B_VALUE,
  input wire logic [7:0] PSW_VALUE,
  input wire logic [7:0] SP_VALUE,
  input wire logic [7:0] STACK_ADDR,
  input wire logic [7:0] BANK_BASE,
  input wire logic [15:0] DATA_POINTER_VALUE,
  input crs_pkg::crs_xbus_type XBUS,
  input wire logic ALE_OUT,
  input wire logic TIMING_1T,
  input wire logic XRAM_ENABLE,
  input wire logic ISP_ENABLE
);
  import crs_pkg::*;
  logic [1:0] mode_q;

  // Shadow of the strobe mode, since the field is not a port
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      mode_q <= ALE_ALWAYS;
    end else if (SFR_REQ.wr && SFR_REQ.addr == ADDR_IFC) begin
      mode_q <= SFR_REQ.wdata[IFC_ALE_HI:IFC_ALE_LO];
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);

  property p_parity; PSW_VALUE[PSW_P] == ^ACC_VALUE; endproperty
  a_parity: assert property (p_parity)
    else $error("parity flag wrong");
  property p_bank;
    BANK_BASE == {3'b000, PSW_VALUE[PSW_RS_HI:PSW_RS_LO], 3'b000};
  endproperty
  a_bank: assert property (p_bank)
    else $error("bank base wrong");
  property p_push;
    CORE_OP.stack_op == STK_PUSH && !SFR_REQ.wr |=>
      SP_VALUE == $past(SP_VALUE) + 8'h01 && STACK_ADDR == SP_VALUE;
  endproperty
  a_push: assert property (p_push)
    else $error("push did not pre-increment");
  property p_read;
    SFR_REQ.rd && !SFR_REQ.wr && SFR_REQ.addr == ADDR_ACC |=>
      SFR_ACK && SFR_RDATA == $past(ACC_VALUE);
  endproperty
  a_read: assert property (p_read)
    else $error("operand read wrong");
  property p_inc;
    CORE_OP.data_pointer_inc && !CORE_OP.data_pointer_load && !SFR_REQ.wr |=>
      DATA_POINTER_VALUE == $past(DATA_POINTER_VALUE) + 16'h0001;
  endproperty
  a_inc: assert property (p_inc)
    else $error("pointer increment wrong");
  property p_xptr;
    CORE_OP.xmove_go && !CORE_OP.xmove_indirect |=>
      XBUS.valid && XBUS.addr == $past(DATA_POINTER_VALUE) && XBUS.internal ==
      ($past(XRAM_ENABLE) && $past(DATA_POINTER_VALUE) < XRAM_BYTES);
  endproperty
  a_xptr: assert property (p_xptr)
    else $error("pointer move wrong");
  property p_xidle; !CORE_OP.xmove_go |=> !XBUS.valid; endproperty
  a_xidle: assert property (p_xidle)
    else $error("move valid without request");
  property p_ifc;
    SFR_REQ.wr && SFR_REQ.addr == ADDR_IFC |=>
      TIMING_1T == $past(SFR_REQ.wdata[IFC_ITS]) &&
      ISP_ENABLE == $past(SFR_REQ.wdata[IFC_IN_SYSTEM_PROG_ENABLE]) &&
      XRAM_ENABLE != $past(SFR_REQ.wdata[IFC_XRAM_DISABLE]);
  endproperty
  a_ifc: assert property (p_ifc)
    else $error("interface control outputs wrong");
  property p_ale;
    (mode_q == ALE_ACCESS) [*2] |-> ALE_OUT == (XBUS.valid && XBUS.external);
  endproperty
  a_ale: assert property (p_ale)
    else $error("strobe not tied to access");
  property p_ale_off; (mode_q[0]) [*2] |-> !ALE_OUT; endproperty
  a_ale_off: assert property (p_ale_off)
    else $error("strobe not suppressed");
  property p_mul;
    CORE_OP.math_op == MATH_MUL && !SFR_REQ.wr |=>
      {B_VALUE, ACC_VALUE} == $past(ACC_VALUE) * $past(B_VALUE) &&
      !PSW_VALUE[PSW_CY] && PSW_VALUE[PSW_OV] == (B_VALUE != 8'h00);
  endproperty
  a_mul: assert property (p_mul)
    else $error("multiply result wrong");
endmodule

bind crs_core_regs crs_core_regs_assertions #(.XRAM_BYTES(XRAM_BYTES)) chk_u (
  .REF_CLK(REF_CLK), .RESETN(RESETN), .SFR_REQ(SFR_REQ),
  .SFR_RDATA(SFR_RDATA), .SFR_ACK(SFR_ACK), .CORE_OP(CORE_OP),
  .PORT2_LATCH(PORT2_LATCH), .CODE_PROTECT_PIN(CODE_PROTECT_PIN),
  .ACC_VALUE(ACC_VALUE), .B_VALUE(B_VALUE), .PSW_VALUE(PSW_VALUE),
  .SP_VALUE(SP_VALUE), .STACK_ADDR(STACK_ADDR), .BANK_BASE(BANK_BASE),
  .DATA_POINTER_VALUE(DATA_POINTER_VALUE), .XBUS(XBUS), .ALE_OUT(ALE_OUT),
  .TIMING_1T(TIMING_1T), .XRAM_ENABLE(XRAM_ENABLE),
  .ISP_ENABLE(ISP_ENABLE)
);

// File: bench/crs_core_regs_bench.sv
module crs_core_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import crs_pkg::*;
  logic ref_clk, resetn, cp_pin, sfr_ack, ale_out, v_x, ale_s;
  logic timing_1t, xram_enable, isp_enable;
  logic [7:0] p2, sfr_rdata, acc_value, b_value, psw_value, sp_value;
  logic [7:0] stack_addr, bank_base, a_s;
  logic [15:0] data_pointer_value;
  crs_xbus_type xbus;
  crs_sfr_req_type req;
  crs_core_op_type op, o;
  int err_total, checks;

  crs_core_regs dut_u (
    .REF_CLK(ref_clk), .RESETN(resetn), .SFR_REQ(req),
    .SFR_RDATA(sfr_rdata), .SFR_ACK(sfr_ack), .CORE_OP(op),
    .PORT2_LATCH(p2), .CODE_PROTECT_PIN(cp_pin), .ACC_VALUE(acc_value),
    .B_VALUE(b_value), .PSW_VALUE(psw_value), .SP_VALUE(sp_value),
    .STACK_ADDR(stack_addr), .BANK_BASE(bank_base),
    .DATA_POINTER_VALUE(data_pointer_value), .XBUS(xbus), .ALE_OUT(ale_out),
    .TIMING_1T(timing_1t), .XRAM_ENABLE(xram_enable),
    .ISP_ENABLE(isp_enable)
  );

  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;

  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp16({8'h00, got}, {8'h00, exp});
  endtask

  // Bus cycles idle one clock after, so no signal is set twice at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    tick;
    cmp8({7'h00, sfr_ack}, 8'h01);
    req = '0;
    tick;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e,
                     input logic k);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    tick;
    cmp8({7'h00, sfr_ack}, {7'h00, k});
    cmp8(sfr_rdata, e);
    req = '0;
    tick;
  endtask

  // Valid and strobe stand one cycle, so they are caught at once
  task automatic core(input crs_core_op_type c);
    op = c;
    tick;
    v_x = xbus.valid;
    ale_s = ale_out;
    op = '0;
    tick;
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  // Hang guard, far beyond the 141 or so cycles the tests need
  initial begin
    repeat (4000) @(posedge ref_clk);
    err_total++;
    end_of_test;
  end

  initial begin
    ref_clk = 1'b0;
    resetn = 1'b0;
    cp_pin = 1'b0;
    p2 = 8'hA5;
    req = '0;
    op = '0;
    err_total = 0;
    checks = 0;
    repeat (10) @(posedge ref_clk);
    #1 resetn = 1'b1;
    rdc(ADDR_SP, RST_SP, 1'b1);
    rdc(ADDR_PAGE, 8'h00, 1'b1);
    rdc(ADDR_IFC, 8'h00, 1'b1);
    cmp8({6'h00, timing_1t, xram_enable}, 8'h01);
    rdc(8'h80, 8'h00, 1'b0);
    done("reset");
    // Shifts stop before bits fall off, so the one count stays fixed
    for (int i = 0; i < 6; i++) begin
      wr(ADDR_ACC, 8'h07 << i);
      cmp8({7'h00, psw_value[PSW_P]}, 8'h01);
      wr(ADDR_ACC, 8'h03 << i);
      cmp8({7'h00, psw_value[PSW_P]}, 8'h00);
    end
    wr(ADDR_ACC, 8'h07);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_PSW, 8'((i << 3) | 8'h22));
      cmp8(bank_base, 8'(i * 8));
      rdc(ADDR_PSW, 8'((i << 3) | 8'h23), 1'b1);
    end
    done("status");
    o = '0;
    o.stack_op = STK_PUSH;
    core(o);
    cmp8(sp_value, 8'h08);
    cmp8(stack_addr, 8'h08);
    o.stack_op = STK_POP;
    core(o);
    cmp8(sp_value, 8'h07);
    cmp8(stack_addr, 8'h08);
    done("stack");
    wr(ADDR_DPL, 8'h34);
    wr(ADDR_DPH, 8'h12);
    wr(ADDR_SECOND_POINTER_LOW, 8'h78);
    wr(ADDR_SECOND_POINTER_HIGH, 8'h56);
    cmp16(data_pointer_value, 16'h1234);
    wr(ADDR_ROUTE, 8'h01);
    cmp16(data_pointer_value, 16'h5678);
    o = '0;
    o.data_pointer_inc = 1'b1;
    core(o);
    cmp16(data_pointer_value, 16'h5679);
    wr(ADDR_ROUTE, 8'h00);
    cmp16(data_pointer_value, 16'h1234);
    rdc(ADDR_SECOND_POINTER_LOW, 8'h79, 1'b1);
    done("pointers");
    wr(ADDR_IFC, 8'h08);
    for (int j = 0; j < 2; j++) begin
      o = '0;
      o.data_pointer_load = 1'b1;
      o.data_pointer_data = 16'h03FF + 16'(j);
      core(o);
      cmp16(data_pointer_value, o.data_pointer_data);
      o = '0;
      o.xmove_go = 1'b1;
      core(o);
      cmp16(xbus.addr, 16'h03FF + 16'(j));
      cmp8({5'h00, xbus.write, v_x, xbus.external}, 8'(2 + j));
      cmp8({7'h00, ale_s}, 8'(j));
    end
    o.xmove_indirect = 1'b1;
    o.xmove_write = 1'b1;
    o.xmove_low = 8'h3C;
    for (int j = 0; j < 2; j++) begin
      wr(ADDR_PAGE, 8'(2 + 3 * j));
      core(o);
      cmp16(xbus.addr, {8'(2 + 3 * j), 8'h3C});
      cmp8({7'h00, xbus.p2_drive}, 8'(j));
      cmp8({6'h00, xbus.write, xbus.internal}, 8'(3 - j));
    end
    wr(ADDR_IFC, 8'h0A);
    cmp8({7'h00, xram_enable}, 8'h00);
    core(o);
    cmp16(xbus.addr, 16'hA53C);
    cmp8({6'h00, xbus.external, ale_s}, 8'h03);
    done("external");
    wr(ADDR_IFC, 8'hFF);
    cmp8({6'h00, timing_1t, xram_enable}, 8'h02);
    cmp8({7'h00, isp_enable}, 8'h01);
    rdc(ADDR_IFC, 8'h8F, 1'b1);
    wr(ADDR_IFC, 8'h04);
    repeat (3) tick;
    cmp8({7'h00, ale_out}, 8'h00);
    cp_pin = 1'b1;
    repeat (5) tick;
    wr(ADDR_IFC, 8'h00);
    rdc(ADDR_IFC, 8'h40, 1'b1);
    a_s = {7'h00, ale_out};
    tick;
    cmp8({7'h00, ale_out}, a_s ^ 8'h01);
    done("control");
    wr(ADDR_ACC, 8'h20);
    wr(ADDR_B, 8'h10);
    o = '0;
    o.math_op = MATH_MUL;
    core(o);
    cmp16({b_value, acc_value}, 16'h0200);
    cmp8(psw_value & 8'h84, 8'h04);
    wr(ADDR_ACC, 8'h07);
    wr(ADDR_B, 8'h02);
    o.math_op = MATH_DIV;
    core(o);
    cmp16({b_value, acc_value}, 16'h0103);
    cmp8(psw_value & 8'h84, 8'h00);
    wr(ADDR_B, 8'h00);
    core(o);
    cmp16({b_value, acc_value}, 16'h0003);
    cmp8(psw_value & 8'h84, 8'h04);
    o = '0;
    o.flag_load = 1'b1;
    o.cy = 1'b1;
    o.ac = 1'b1;
    o.acc_load = 1'b1;
    o.acc_data = 8'h81;
    core(o);
    cmp8(psw_value & 8'hC5, 8'hC0);
    rdc(ADDR_ACC, 8'h81, 1'b1);
    done("math");
    end_of_test;
  end
endmodule
